/* hdl/protector_gate_pkg.sv */
// Shared constants and carrier types for the protector gate decision block
package protector_gate_pkg;

  // Clock and internal sample rate
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_US = 100;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_US * 1000 / CLK_PERIOD_NS;
  localparam int SAMPLE_W = 16;

  // Override deglitch: counter full range set so a solid signal crosses 70% in 7 ms
  localparam int OVR_DEGLITCH_US = 7000;
  localparam int OVR_ON_PCT = 70;
  localparam int OVR_OFF_PCT = 30;
  localparam int OVR_FULL = OVR_DEGLITCH_US * 100 / (SAMPLE_PERIOD_US * OVR_ON_PCT);
  localparam int OVR_W = 7;
  localparam logic [OVR_W-1:0] OVR_FULL_C = OVR_W'(OVR_FULL);
  localparam logic [OVR_W-1:0] OVR_ON_LEVEL = OVR_W'(OVR_FULL * OVR_ON_PCT / 100);
  localparam logic [OVR_W-1:0] OVR_OFF_LEVEL = OVR_W'(OVR_FULL * OVR_OFF_PCT / 100);
  localparam logic [OVR_W-1:0] OVR_ZERO = 7'h00;

  // Cell-count pin deglitch in whole samples
  localparam int CELL_DEG_US = 10000;
  localparam int CELL_W = 7;
  localparam logic [CELL_W-1:0] CELL_DEG_LAST = CELL_W'(CELL_DEG_US / SAMPLE_PERIOD_US - 1);

  // Levels reported by the cell-count pin comparators
  localparam logic [1:0] LEVEL_LOW = 2'h0;
  localparam logic [1:0] LEVEL_MID = 2'h1;
  localparam logic [1:0] LEVEL_HIGH = 2'h2;

  typedef enum logic [1:0] {
    CELLS_3 = 2'h0,
    CELLS_4 = 2'h1,
    CELLS_5 = 2'h2
  } cell_cfg_t;

  typedef enum logic [1:0] {
    PWR_HOLD = 2'b00,
    PWR_RUN = 2'b01,
    PWR_SHUT = 2'b11
  } power_state_t;

  // Register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h8;

  // Event bits of status and mask
  localparam int EV_W = 5;
  localparam int EV_DISCHARGE_OFF = 0;
  localparam int EV_CHARGE_OFF = 1;
  localparam int EV_OVERRIDE = 2;
  localparam int EV_CELL_CFG = 3;
  localparam int EV_SHUTDOWN = 4;
  localparam logic [EV_W-1:0] MASK_RESET = 5'h00;

  // Fields of the state register
  localparam int ST_DISCHARGE_GATE = 0;
  localparam int ST_CHARGE_GATE = 1;
  localparam int ST_DISCHARGE_OVR = 2;
  localparam int ST_CHARGE_OVR = 3;
  localparam int ST_CELL_LO = 4;
  localparam int ST_CELL_HI = 5;
  localparam int ST_CELL_VALID = 6;
  localparam int ST_UV_FORCED = 7;
  localparam int ST_POWER_LO = 8;
  localparam int ST_POWER_HI = 9;
  localparam int ST_OC_EN = 10;

  typedef struct packed {
    logic undervoltage_fault;
    logic overvoltage_fault;
    logic open_wire_fault;
    logic overtemp_discharge_fault;
    logic undertemp_discharge_fault;
    logic overtemp_charge_fault;
    logic undertemp_charge_fault;
    logic overcurrent_level1_fault;
    logic overcurrent_level2_fault;
    logic short_circuit_fault;
  } fault_flags_t;

  typedef struct packed {
    logic charge_override_in;
    logic discharge_override_in;
    logic sense_above_charge_threshold;
    logic sense_at_or_below_discharge_threshold;
    logic supply_above_shutdown;
    logic supply_above_por;
    logic [1:0] cell_level;
    logic small_variant;
  } pin_in_t;

  typedef struct packed {
    logic discharge_gate_out;
    logic charge_gate_out;
    logic chain_charge_out;
    logic overcurrent_detect_en;
    logic state_comp_charge_en;
    logic state_comp_discharge_en;
    logic body_diode_guard_en;
  } gate_out_t;

endpackage

/* hdl/protector_fet_gate_control.sv */
// Gate decision logic for the charge and discharge drivers of a stackable protector
module protector_fet_gate_control
  import protector_gate_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire fault_flags_t FAULTS,
  input wire pin_in_t PINS,
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  output logic IRQ,
  output gate_out_t GATES
);

  typedef struct packed {
    pin_in_t pin_meta;
    pin_in_t pin_sync;
    fault_flags_t fault;
    logic [SAMPLE_W-1:0] tick_cnt;
    logic tick;
    logic [OVR_W-1:0] charge_ovr_cnt;
    logic [OVR_W-1:0] discharge_ovr_cnt;
    logic charge_ovr_en;
    logic discharge_ovr_en;
    logic [1:0] cell_cand;
    logic [CELL_W-1:0] cell_stable_cnt;
    cell_cfg_t cell_cfg;
    logic cell_valid;
    logic undervoltage_forced;
    power_state_t power;
    gate_out_t gates;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic irq;
    logic [DATA_W-1:0] rdata;
  } state_t;

  localparam logic [SAMPLE_W-1:0] TICK_LAST = SAMPLE_W'(SAMPLE_CYCLES_P - 1);
  localparam logic [SAMPLE_W-1:0] TICK_ZERO = 16'h0000;
  localparam logic [CELL_W-1:0] CELL_ZERO = 7'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  // Saturating up/down step of an override filter counter
  function automatic logic [OVR_W-1:0] ovr_step(input logic [OVR_W-1:0] cnt,
                                                input logic enabled);
    logic [OVR_W-1:0] nxt;
    nxt = cnt;
    if (enabled) begin
      if (cnt != OVR_FULL_C) begin
        nxt = cnt + 7'h01;
      end
    end else begin
      if (cnt != OVR_ZERO) begin
        nxt = cnt - 7'h01;
      end
    end
    return nxt;
  endfunction

  // Hysteresis decision on a filter count
  function automatic logic ovr_decide(input logic cur, input logic [OVR_W-1:0] cnt);
    logic res;
    res = cur;
    if (cnt > OVR_ON_LEVEL) begin
      res = 1'b1;
    end else if (cnt < OVR_OFF_LEVEL) begin
      res = 1'b0;
    end
    return res;
  endfunction

  logic [1:0] rst_sync_q;
  logic rst_n_int;
  state_t s_q;
  state_t s_d;

  // Reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  assign rst_n_int = rst_sync_q[1];

  // Decision logic feeding the whole state copy
  always_comb begin
    logic discharge_prot;
    logic charge_prot;
    logic discharge_only;
    logic charge_only;
    logic charge_permitted;
    logic next_discharge;
    logic next_charge;
    logic [EV_W-1:0] events;
    logic [EV_W-1:0] clear_bits;
    logic [1:0] level;
    logic valid_level;
    cell_cfg_t level_cfg;

    s_d = s_q;
    discharge_prot = 1'b0;
    charge_prot = 1'b0;
    discharge_only = 1'b0;
    charge_only = 1'b0;
    charge_permitted = 1'b0;
    next_discharge = 1'b0;
    next_charge = 1'b0;
    events = '0;
    clear_bits = '0;
    level = s_q.pin_sync.cell_level;
    valid_level = 1'b1;
    level_cfg = CELLS_3;

    // Pin synchronisers and registered fault flags
    s_d.pin_meta = PINS;
    s_d.pin_sync = s_q.pin_meta;
    s_d.fault = FAULTS;

    // Sample clock divider
    s_d.tick = 1'b0;
    if (s_q.tick_cnt == TICK_LAST) begin
      s_d.tick_cnt = TICK_ZERO;
      s_d.tick = 1'b1;
    end else begin
      s_d.tick_cnt = s_q.tick_cnt + 16'h0001;
    end

    if (s_q.tick) begin
      s_d.charge_ovr_cnt = ovr_step(s_q.charge_ovr_cnt, s_q.pin_sync.charge_override_in);
      s_d.discharge_ovr_cnt = ovr_step(s_q.discharge_ovr_cnt,
                                       s_q.pin_sync.discharge_override_in);
      s_d.charge_ovr_en = ovr_decide(s_q.charge_ovr_en, s_q.charge_ovr_cnt);
      s_d.discharge_ovr_en = ovr_decide(s_q.discharge_ovr_en, s_q.discharge_ovr_cnt);

      unique case (level)
        LEVEL_LOW: level_cfg = CELLS_3;
        LEVEL_MID: level_cfg = CELLS_4;
        LEVEL_HIGH: level_cfg = CELLS_5;
        default: valid_level = 1'b0;
      endcase
      if (level != s_q.cell_cand) begin
        s_d.cell_cand = level;
        s_d.cell_stable_cnt = CELL_ZERO;
      end else if (s_q.cell_stable_cnt != CELL_DEG_LAST) begin
        s_d.cell_stable_cnt = s_q.cell_stable_cnt + 7'h01;
      end else if (valid_level) begin
        s_d.cell_cfg = level_cfg;
        s_d.cell_valid = 1'b1;
      end

      s_d.undervoltage_forced = s_q.pin_sync.small_variant & s_q.cell_valid &
                                (s_q.cell_cfg == CELLS_5);

      unique case (s_q.power)
        PWR_HOLD: begin
          if (s_q.pin_sync.supply_above_por) begin
            s_d.power = PWR_RUN;
          end
        end
        PWR_RUN: begin
          if (!s_q.pin_sync.supply_above_shutdown) begin
            s_d.power = PWR_SHUT;
          end
        end
        PWR_SHUT: begin
          if (s_q.pin_sync.supply_above_por) begin
            s_d.power = PWR_RUN;
          end
        end
        default: s_d.power = PWR_HOLD;
      endcase

      // faults that stop the discharge gate
      discharge_prot = s_q.fault.undervoltage_fault | s_q.undervoltage_forced |
                       s_q.fault.open_wire_fault | s_q.fault.overtemp_discharge_fault |
                       s_q.fault.undertemp_discharge_fault |
                       s_q.fault.overcurrent_level1_fault |
                       s_q.fault.overcurrent_level2_fault | s_q.fault.short_circuit_fault;
      // faults that stop the charge gate
      charge_prot = s_q.fault.overvoltage_fault | s_q.fault.open_wire_fault |
                    s_q.fault.overtemp_charge_fault | s_q.fault.undertemp_charge_fault |
                    s_q.fault.overtemp_discharge_fault |
                    s_q.fault.undertemp_discharge_fault |
                    s_q.fault.overcurrent_level1_fault |
                    s_q.fault.overcurrent_level2_fault | s_q.fault.short_circuit_fault;
      discharge_only = discharge_prot & ~charge_prot;
      charge_only = charge_prot & ~discharge_prot;

      // charge current lets the discharge gate through
      next_discharge = ~discharge_prot |
                       (discharge_only & s_q.pin_sync.sense_above_charge_threshold);
      // discharge current lets the charge gate through
      next_charge = ~charge_prot |
                    (charge_only & s_q.pin_sync.sense_at_or_below_discharge_threshold);

      // charge only while supply is up and powered on
      charge_permitted = (s_q.power == PWR_RUN) & s_q.pin_sync.supply_above_shutdown;

      // override disable forces only its own gate off
      // override enabled leaves protection in charge
      // upper device faults reach us through the overrides
      s_d.gates.discharge_gate_out = s_q.discharge_ovr_en & next_discharge;
      s_d.gates.charge_gate_out = s_q.charge_ovr_en & charge_permitted & next_charge;
      s_d.gates.chain_charge_out = s_q.charge_ovr_en & charge_permitted & next_charge;
      // overcurrent detection follows the discharge gate
      // charge gate plays no part here
      s_d.gates.overcurrent_detect_en = s_q.gates.discharge_gate_out;
      s_d.gates.state_comp_charge_en = discharge_only;
      s_d.gates.state_comp_discharge_en = charge_only;
      // guard only with exactly one gate on
      s_d.gates.body_diode_guard_en = s_q.gates.discharge_gate_out ^
                                      s_q.gates.charge_gate_out;
    end

    // gate outputs change only from registered state, once per sample
    // Event detection on registered state
    events[EV_DISCHARGE_OFF] = s_q.gates.discharge_gate_out & ~s_d.gates.discharge_gate_out;
    events[EV_CHARGE_OFF] = s_q.gates.charge_gate_out & ~s_d.gates.charge_gate_out;
    events[EV_OVERRIDE] = (s_q.charge_ovr_en ^ s_d.charge_ovr_en) |
                          (s_q.discharge_ovr_en ^ s_d.discharge_ovr_en);
    events[EV_CELL_CFG] = (s_d.cell_valid & ~s_q.cell_valid) |
                          (s_d.cell_cfg != s_q.cell_cfg);
    events[EV_SHUTDOWN] = (s_d.power == PWR_SHUT) & (s_q.power != PWR_SHUT);

    // Register writes; status bits clear on writing one, a new event wins
    if (WR && (ADDR == REG_STATUS)) begin
      clear_bits = WDATA[EV_W-1:0];
    end
    if (WR && (ADDR == REG_MASK)) begin
      s_d.mask = WDATA[EV_W-1:0];
    end
    s_d.status = (s_q.status & ~clear_bits) | events;
    s_d.irq = |(s_d.status & s_d.mask);

    // Read data stands only in the cycle after the strobe
    s_d.rdata = DATA_ZERO;
    if (RD) begin
      unique case (ADDR)
        REG_STATUS: s_d.rdata[EV_W-1:0] = s_q.status;
        REG_MASK: s_d.rdata[EV_W-1:0] = s_q.mask;
        REG_STATE: begin
          s_d.rdata[ST_DISCHARGE_GATE] = s_q.gates.discharge_gate_out;
          s_d.rdata[ST_CHARGE_GATE] = s_q.gates.charge_gate_out;
          s_d.rdata[ST_DISCHARGE_OVR] = s_q.discharge_ovr_en;
          s_d.rdata[ST_CHARGE_OVR] = s_q.charge_ovr_en;
          s_d.rdata[ST_CELL_HI:ST_CELL_LO] = s_q.cell_cfg;
          s_d.rdata[ST_CELL_VALID] = s_q.cell_valid;
          s_d.rdata[ST_UV_FORCED] = s_q.undervoltage_forced;
          s_d.rdata[ST_POWER_HI:ST_POWER_LO] = s_q.power;
          s_d.rdata[ST_OC_EN] = s_q.gates.overcurrent_detect_en;
        end
        default: s_d.rdata = DATA_ZERO;
      endcase
    end
  end

  // State register; clock enable freezes everything
  always_ff @(posedge CLK or negedge rst_n_int) begin
    if (!rst_n_int) begin
      s_q.pin_meta <= '0;
      s_q.pin_sync <= '0;
      s_q.fault <= '0;
      s_q.tick_cnt <= TICK_ZERO;
      s_q.tick <= 1'b0;
      s_q.charge_ovr_cnt <= OVR_ZERO;
      s_q.discharge_ovr_cnt <= OVR_ZERO;
      s_q.charge_ovr_en <= 1'b0;
      s_q.discharge_ovr_en <= 1'b0;
      s_q.cell_cand <= LEVEL_LOW;
      s_q.cell_stable_cnt <= CELL_ZERO;
      s_q.cell_cfg <= CELLS_3;
      s_q.cell_valid <= 1'b0;
      s_q.undervoltage_forced <= 1'b0;
      s_q.power <= PWR_HOLD;
      s_q.gates <= '0;
      s_q.status <= '0;
      s_q.mask <= MASK_RESET;
      s_q.irq <= 1'b0;
      s_q.rdata <= DATA_ZERO;
    end else if (CE) begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign GATES = s_q.gates;
  assign IRQ = s_q.irq;
  assign RDATA = s_q.rdata;

endmodule // protector_fet_gate_control

/* bench/protector_gate_chk.sv */
// Port-level assertions for the protector gate decision block
module protector_gate_chk
  import protector_gate_pkg::*;
#(
  parameter int SAMPLE_CYCLES_P = SAMPLE_CYCLES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire fault_flags_t FAULTS,
  input wire pin_in_t PINS,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  input wire gate_out_t GATES
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] LIM = 16'(3 * SAMPLE_CYCLES_P + 4);
  logic [9:0] f;
  logic [3:0] cond;
  logic [3:0][15:0] cnt_q;

  // Held conditions: 3 kill both, 2 discharge-only, 1 charge-only, 0 low supply
  assign f = FAULTS;
  assign cond[3] = |(f & 10'h0E7);
  assign cond[2] = |(f & 10'h2E7) & ~|(f & 10'h1FF) & ~PINS.sense_above_charge_threshold;
  assign cond[1] = |(f & 10'h1FF) & ~|(f & 10'h2E7) & ~PINS.sense_at_or_below_discharge_threshold;
  assign cond[0] = ~PINS.supply_above_shutdown;

  // Cycle counters of each held condition, saturating
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      cnt_q <= '0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        cnt_q[i] <= !cond[i] ? 16'h0000 : (cnt_q[i] == 16'hFFFF ? cnt_q[i] : cnt_q[i] + 16'h0001);
      end
    end
  end

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_held(int i);
    cnt_q[i] >= LIM;
  endsequence

  AST_CHAIN_SAME: assert property (GATES.chain_charge_out == GATES.charge_gate_out)
    else $error("chain charge output differs from charge gate");
  AST_KILL_BOTH: assert property (s_held(3) |-> !GATES.discharge_gate_out &&
    !GATES.charge_gate_out && !GATES.state_comp_charge_en && !GATES.state_comp_discharge_en)
    else $error("gate left on under a shared fault");
  AST_OC_FOLLOWS_DSG: assert property ($changed(GATES.overcurrent_detect_en) |->
    GATES.overcurrent_detect_en == $past(GATES.discharge_gate_out))
    else $error("overcurrent enable not following discharge gate");
  AST_GUARD_XOR: assert property ($changed(GATES.body_diode_guard_en) |->
    GATES.body_diode_guard_en == $past(GATES.discharge_gate_out ^ GATES.charge_gate_out))
    else $error("body diode guard not one gate on");
  AST_DONLY_CMP: assert property (s_held(2) |-> GATES.state_comp_charge_en)
    else $error("charge comparator off in discharge-only fault");
  AST_DONLY_DSG: assert property (s_held(2) |-> !GATES.discharge_gate_out)
    else $error("discharge gate on without charge current");
  AST_CONLY_CHG: assert property (s_held(1) |-> !GATES.charge_gate_out &&
    GATES.state_comp_discharge_en)
    else $error("charge gate wrong in charge-only fault");
  AST_SUPPLY_CHG: assert property (s_held(0) |-> !GATES.charge_gate_out)
    else $error("charge gate on below shutdown supply");
  AST_RDATA_IDLE: assert property (!$past(RD) |-> RDATA == '0)
    else $error("read data not zero outside read answer");
endmodule // protector_gate_chk

bind protector_fet_gate_control protector_gate_chk #(.SAMPLE_CYCLES_P(SAMPLE_CYCLES_P)) chk (
  .CLK(CLK), .RST_N(RST_N), .FAULTS(FAULTS), .PINS(PINS), .RD(RD), .RDATA(RDATA),
  .GATES(GATES));

/* bench/upper_protector_model.sv */
// Upper stacked protector that drives the override inputs of the device below
module upper_protector_model #(
  parameter int SAMPLE_CYCLES_P = 4
) (
  input wire logic CLK,
  input wire logic dsg_fault,
  input wire logic chg_fault,
  input wire logic noisy,
  output logic discharge_gate_out,
  output logic chain_charge_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic phase_q = 1'b0;
  logic dsg_q = 1'b1;
  logic chg_q = 1'b1;
  int cnt = 0;

  // faults pass down
  // Noise mode flips the discharge line once per sample period
  always @(posedge CLK) begin
    cnt <= (cnt == SAMPLE_CYCLES_P - 1) ? 0 : cnt + 1;
    if (cnt == 0) begin
      phase_q <= ~phase_q;
    end
    dsg_q <= ~dsg_fault & ~(noisy & phase_q);
    chg_q <= ~chg_fault;
  end

  assign discharge_gate_out = dsg_q;
  assign chain_charge_out = chg_q;
endmodule // upper_protector_model

/* bench/tb_top.sv */
// Self-checking bench for the protector gate decision block
module tb_top
  import protector_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int S = 4;
  logic CLK = 1'b0;
  logic RST_N = 1'b0;
  logic CE = 1'b1;
  fault_flags_t FAULTS = '0;
  pin_in_t pin_q = '0;
  pin_in_t PINS;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [DATA_W-1:0] WDATA = '0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [DATA_W-1:0] RDATA;
  logic IRQ;
  gate_out_t GATES;
  logic dsg_fault = 1'b0;
  logic chg_fault = 1'b0;
  logic noisy = 1'b0;
  logic up_dsg;
  logic up_chg;
  logic [31:0] rv;
  logic [1:0] lvl [3] = '{LEVEL_HIGH, LEVEL_LOW, LEVEL_MID};
  logic [3:0] exp_cell [3] = '{4'hC, 4'h1, 4'h3};
  int fails = 0;
  int n_compared = 0;

  always #5 CLK = ~CLK;

  // Override inputs come from the upper device
  always_comb begin
    PINS = pin_q;
    PINS.charge_override_in = up_chg;
    PINS.discharge_override_in = up_dsg;
  end

  protector_fet_gate_control #(.SAMPLE_CYCLES_P(S)) dut (
    .CLK(CLK), .RST_N(RST_N), .CE(CE), .FAULTS(FAULTS), .PINS(PINS), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .GATES(GATES));
  upper_protector_model #(.SAMPLE_CYCLES_P(S)) upper (
    .CLK(CLK), .dsg_fault(dsg_fault), .chg_fault(chg_fault), .noisy(noisy),
    .discharge_gate_out(up_dsg), .chain_charge_out(up_chg));

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic smp(input int n);
    repeat (n * S) @(posedge CLK);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge CLK);
    WR <= 1'b1;
    ADDR <= a;
    WDATA <= d;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge CLK);
    RD <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD <= 1'b0;
    // Answer stands in the cycle after the strobe edge; take it at the next edge
    @(posedge CLK);
    d = RDATA;
  endtask

  task automatic rchk(input string what, input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    rd(a, rv);
    chk(what, exp, rv);
  endtask

  // Expected gate word for one fault pattern and sense level
  function automatic logic [31:0] expg(input logic [9:0] f, input logic s);
    logic dp;
    logic cp;
    logic d;
    logic c;
    dp = |(f & 10'h2E7);
    cp = |(f & 10'h1FF);
    d = !dp | (!cp & s);
    c = !cp | (!dp & s);
    return {25'h0, d, c, c, d, dp & !cp, cp & !dp, d ^ c};
  endfunction

  function automatic logic [31:0] gp();
    return {30'h0, GATES.discharge_gate_out, GATES.charge_gate_out};
  endfunction

  // Main sequence
  initial begin
    pin_q.supply_above_shutdown = 1'b1;
    pin_q.supply_above_por = 1'b1;
    pin_q.cell_level = LEVEL_MID;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    smp(60);
    chk("gates early", 32'h0, {25'h0, GATES});
    smp(50);
    chk("gates up", expg(10'h0, 1'b0), {25'h0, GATES});
    rchk("state", REG_STATE, 32'h0000055F);
    rchk("status", REG_STATUS, 32'h0000000C);
    rchk("unmapped", 4'hC, 32'h0);
    wr(REG_MASK, 32'h0000000C);
    rchk("mask", REG_MASK, 32'h0000000C);
    chk("irq on", 32'h1, {31'h0, IRQ});
    wr(REG_STATUS, 32'h0000000C);
    rchk("status clr", REG_STATUS, 32'h0);
    chk("irq off", 32'h0, {31'h0, IRQ});
    $display("test registers done");
    // Clock enable low freezes the gates against a full fault set
    CE <= 1'b0;
    FAULTS <= fault_flags_t'(10'h3FF);
    smp(3);
    chk("frozen", expg(10'h0, 1'b0), {25'h0, GATES});
    FAULTS <= '0;
    CE <= 1'b1;
    smp(2);
    $display("test enable done");
    for (int j = 0; j < 20; j++) begin
      @(posedge CLK);
      FAULTS <= fault_flags_t'(10'h1 << (j % 10));
      pin_q.sense_above_charge_threshold <= (j >= 10);
      pin_q.sense_at_or_below_discharge_threshold <= (j >= 10);
      smp(4);
      chk("gates fault", expg(10'h1 << (j % 10), j >= 10), {25'h0, GATES});
      FAULTS <= '0;
      smp(4);
    end
    pin_q.sense_above_charge_threshold <= 1'b0;
    pin_q.sense_at_or_below_discharge_threshold <= 1'b0;
    $display("test faults done");
    dsg_fault <= 1'b1;
    smp(50);
    chk("override held", 32'h3, gp());
    smp(60);
    chk("override off", 32'h1, gp());
    dsg_fault <= 1'b0;
    noisy <= 1'b1;
    smp(100);
    chk("override noisy", 32'h1, gp());
    noisy <= 1'b0;
    smp(80);
    chk("override on", 32'h3, gp());
    chg_fault <= 1'b1;
    smp(80);
    chk("chain off", 32'h2, gp());
    chg_fault <= 1'b0;
    smp(80);
    chk("chain on", 32'h3, gp());
    $display("test overrides done");
    pin_q.supply_above_shutdown <= 1'b0;
    pin_q.supply_above_por <= 1'b0;
    smp(6);
    chk("shutdown", 32'h2, gp());
    rd(REG_STATE, rv);
    chk("power", 32'h3, {30'h0, rv[9:8]});
    pin_q.supply_above_shutdown <= 1'b1;
    smp(3);
    chk("wait por", 32'h2, gp());
    pin_q.supply_above_por <= 1'b1;
    smp(3);
    chk("power back", 32'h3, gp());
    $display("test supply done");
    for (int k = 0; k < 3; k++) begin
      @(posedge CLK);
      pin_q.cell_level <= lvl[k];
      pin_q.small_variant <= (k == 0);
      smp(50);
      rd(REG_STATE, rv);
      chk("cell held", {30'h0, exp_cell[(k + 2) % 3][2:1]}, {30'h0, rv[5:4]});
      smp(60);
      rd(REG_STATE, rv);
      chk("cell mode", {28'h0, exp_cell[k]}, {28'h0, rv[7], rv[5:4], rv[0]});
    end
    $display("test cells done");
    @(posedge CLK);
    RST_N <= 1'b0;
    smp(2);
    chk("reset gates", 32'h0, {25'h0, GATES});
    RST_N <= 1'b1;
    smp(60);
    chk("gates after reset", 32'h0, gp());
    $display("test reset done");
    end_sim();
  end

  // Watchdog against a hang
  initial begin
    #300000;
    fails++;
    $display("watchdog expired");
    end_sim();
  end
endmodule // tb_top
